// File: bench/rst_seq_sva.sv
// checker for the chip reset sequencer, bound to its top ports
// assumes one clock domain and the hand-over latencies
`timescale 1ns/1ps
module rst_seq_sva (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic RESET_N_I,
	input wire logic WDT_OVERFLOW_I,
	input wire logic [7:0] VECTOR_DATA_I,
	input wire logic [19:0] VECTOR_ADDR_O,
	input wire logic VECTOR_RD_O,
	input wire logic CORE_CLK_EN_O,
	input wire logic FAST_OSC_SELECT_O,
	input wire logic CRYSTAL_OSC_EN_O,
	input wire logic CRYSTAL_PINS_AS_INPUT_O,
	input wire logic EXT_CLOCK_ACCEPT_O,
	input wire logic LOW_VOLTAGE_DETECTOR_EN_O,
	input wire logic PULL_UP_PORT_PIN_O,
	input wire logic PULL_UP_PORT_PIN_OE_O,
	input wire logic PERIPH_STOP_O,
	input wire logic [19:0] PROGRAM_COUNTER_O,
	input wire logic [7:0] PROGRAM_STATUS_WORD_O,
	input wire logic PSW_LOAD_O
);
	// ====
	// properties
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (RST_I);
	chk_pin_holds_core: assert property ((!RESET_N_I) [*8] |-> !CORE_CLK_EN_O && !PULL_UP_PORT_PIN_OE_O)
		else $error("core or pull-up active during pin reset");
	chk_stop_tracks_run: assert property (PERIPH_STOP_O == !CORE_CLK_EN_O)
		else $error("peripheral stop disagrees with core clock");
	chk_clock_sources: assert property (FAST_OSC_SELECT_O && !CRYSTAL_OSC_EN_O && CRYSTAL_PINS_AS_INPUT_O && !EXT_CLOCK_ACCEPT_O)
		else $error("clock source outputs wrong");
	chk_fault_stops_all: assert property (WDT_OVERFLOW_I |-> ##2 !CORE_CLK_EN_O && !LOW_VOLTAGE_DETECTOR_EN_O)
		else $error("fault did not stop core and detector");
	chk_psw_constant: assert property (PROGRAM_STATUS_WORD_O == 8'h06)
		else $error("status word not 06");
	chk_vector_order: assert property (VECTOR_RD_O && VECTOR_ADDR_O == 20'h0 |=> VECTOR_RD_O && VECTOR_ADDR_O == 20'h1 ##1 !VECTOR_RD_O ##1 PSW_LOAD_O)
		else $error("vector fetch order wrong");
	chk_pc_from_vector: assert property (PSW_LOAD_O |-> PROGRAM_COUNTER_O == {4'h0, $past(VECTOR_DATA_I), $past(VECTOR_DATA_I, 2)})
		else $error("program counter not from vector bytes");
	chk_run_after_load: assert property (PSW_LOAD_O |=> CORE_CLK_EN_O && PULL_UP_PORT_PIN_OE_O && PULL_UP_PORT_PIN_O)
		else $error("core not started after load");
	chk_start_needs_load: assert property ($rose(CORE_CLK_EN_O) |-> $past(PSW_LOAD_O))
		else $error("core started without load");
	cover property (PSW_LOAD_O);
	cover property (WDT_OVERFLOW_I);
	cover property ((!RESET_N_I) [*8]);
endmodule
bind chip_reset_sequencer rst_seq_sva chk_i (
	.CLK_I(CLK_I),
	.RST_I(RST_I),
	.RESET_N_I(RESET_N_I),
	.WDT_OVERFLOW_I(WDT_OVERFLOW_I),
	.VECTOR_DATA_I(VECTOR_DATA_I),
	.VECTOR_ADDR_O(VECTOR_ADDR_O),
	.VECTOR_RD_O(VECTOR_RD_O),
	.CORE_CLK_EN_O(CORE_CLK_EN_O),
	.FAST_OSC_SELECT_O(FAST_OSC_SELECT_O),
	.CRYSTAL_OSC_EN_O(CRYSTAL_OSC_EN_O),
	.CRYSTAL_PINS_AS_INPUT_O(CRYSTAL_PINS_AS_INPUT_O),
	.EXT_CLOCK_ACCEPT_O(EXT_CLOCK_ACCEPT_O),
	.LOW_VOLTAGE_DETECTOR_EN_O(LOW_VOLTAGE_DETECTOR_EN_O),
	.PULL_UP_PORT_PIN_O(PULL_UP_PORT_PIN_O),
	.PULL_UP_PORT_PIN_OE_O(PULL_UP_PORT_PIN_OE_O),
	.PERIPH_STOP_O(PERIPH_STOP_O),
	.PROGRAM_COUNTER_O(PROGRAM_COUNTER_O),
	.PROGRAM_STATUS_WORD_O(PROGRAM_STATUS_WORD_O),
	.PSW_LOAD_O(PSW_LOAD_O)
);

// File: bench/tb_chip_reset_sequencer.sv
// self-checking bench for the chip reset sequencer with short timing parameters
// assumes the vector table model and the bound checker
`timescale 1ns/1ps
module tb_chip_reset_sequencer;
	localparam int P_FL = 20, P_FN = 12, P_LL = 16, P_LN = 8, P_ST = 30;
	localparam logic [7:0] LO = 8'h5a, HI = 8'hc3;
	logic CLK_I = 1'b0, RST_I = 1'b1, RESET_N_I = 1'b0, POR_SUPPLY_OK_I = 1'b1;
	logic LVD_SUPPLY_OK_I = 1'b1, LVD_ENABLED_I = 1'b1;
	logic WDT_OVERFLOW_I = 1'b0, ILLEGAL_INSTR_I = 1'b0, RAM_PARITY_ERR_I = 1'b0;
	logic ILLEGAL_ACCESS_I = 1'b0, VECTOR_RD_O, CORE_CLK_EN_O, CORE_RUN_O, FAST_OSC_SELECT_O;
	logic CRYSTAL_OSC_EN_O, CRYSTAL_PINS_AS_INPUT_O, EXT_CLOCK_ACCEPT_O, PSW_LOAD_O;
	logic LOW_VOLTAGE_DETECTOR_EN_O, PULL_UP_PORT_PIN_O, PULL_UP_PORT_PIN_OE_O, PERIPH_STOP_O;
	logic PROGRAM_COUNTER_VALID_O;
	logic [7:0] VECTOR_DATA_I, PROGRAM_STATUS_WORD_O;
	logic [19:0] VECTOR_ADDR_O, PROGRAM_COUNTER_O;
	int fail_count = 0, tests_run = 0;
	int t[4];
	always #20 CLK_I = ~CLK_I;
	chip_reset_sequencer #(.PROC_FIRST_LVD(P_FL), .PROC_FIRST_NOLVD(P_FN),
		.PROC_LATER_LVD(P_LL), .PROC_LATER_NOLVD(P_LN), .STAB_CYCLES(P_ST)) dut (
		.CLK_I(CLK_I), .RST_I(RST_I), .RESET_N_I(RESET_N_I), .POR_SUPPLY_OK_I(POR_SUPPLY_OK_I),
		.LVD_SUPPLY_OK_I(LVD_SUPPLY_OK_I), .LVD_ENABLED_I(LVD_ENABLED_I),
		.WDT_OVERFLOW_I(WDT_OVERFLOW_I), .ILLEGAL_INSTR_I(ILLEGAL_INSTR_I),
		.RAM_PARITY_ERR_I(RAM_PARITY_ERR_I), .ILLEGAL_ACCESS_I(ILLEGAL_ACCESS_I),
		.VECTOR_DATA_I(VECTOR_DATA_I), .VECTOR_ADDR_O(VECTOR_ADDR_O), .VECTOR_RD_O(VECTOR_RD_O),
		.CORE_CLK_EN_O(CORE_CLK_EN_O), .CORE_RUN_O(CORE_RUN_O),
		.FAST_OSC_SELECT_O(FAST_OSC_SELECT_O), .CRYSTAL_OSC_EN_O(CRYSTAL_OSC_EN_O),
		.CRYSTAL_PINS_AS_INPUT_O(CRYSTAL_PINS_AS_INPUT_O), .EXT_CLOCK_ACCEPT_O(EXT_CLOCK_ACCEPT_O),
		.LOW_VOLTAGE_DETECTOR_EN_O(LOW_VOLTAGE_DETECTOR_EN_O),
		.PULL_UP_PORT_PIN_O(PULL_UP_PORT_PIN_O), .PULL_UP_PORT_PIN_OE_O(PULL_UP_PORT_PIN_OE_O),
		.PERIPH_STOP_O(PERIPH_STOP_O), .PROGRAM_COUNTER_O(PROGRAM_COUNTER_O),
		.PROGRAM_COUNTER_VALID_O(PROGRAM_COUNTER_VALID_O),
		.PROGRAM_STATUS_WORD_O(PROGRAM_STATUS_WORD_O), .PSW_LOAD_O(PSW_LOAD_O)
	);
	vec_rom #(.LO(LO), .HI(HI)) rom (.clk_i(CLK_I), .rd_i(VECTOR_RD_O), .addr_i(VECTOR_ADDR_O),
		.data_o(VECTOR_DATA_I));
	// ====
	// helpers
	task automatic complete_run;
		if (fail_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_run(output int n);
		n = 0;
		while (CORE_CLK_EN_O !== 1'b1 && n < 200) begin
			@(negedge CLK_I);
			n++;
		end
		chk(20'(n < 200), 20'h1);
		chk(20'(PROGRAM_COUNTER_VALID_O), 20'h1);
	endtask
	task automatic hard_reset(input logic low_voltage_detector);
		LVD_ENABLED_I = low_voltage_detector;
		RESET_N_I = 1'b0;
		RST_I = 1'b1;
		repeat (4) @(negedge CLK_I);
		RST_I = 1'b0;
	endtask
	// ====
	// scenarios
	task automatic pin_cycle(input logic low_voltage_detector, output int n);
		LVD_ENABLED_I = low_voltage_detector;
		RESET_N_I = 1'b0;
		repeat (250) @(negedge CLK_I);
		chk(20'({CORE_CLK_EN_O, PULL_UP_PORT_PIN_OE_O, LOW_VOLTAGE_DETECTOR_EN_O}), 20'h0);
		chk(20'({FAST_OSC_SELECT_O, CRYSTAL_OSC_EN_O, CRYSTAL_PINS_AS_INPUT_O, EXT_CLOCK_ACCEPT_O,
			PERIPH_STOP_O}), 20'h15);
		RESET_N_I = 1'b1;
		wait_run(n);
		chk(PROGRAM_COUNTER_O, {4'h0, HI, LO});
		chk(20'({PROGRAM_STATUS_WORD_O, PULL_UP_PORT_PIN_OE_O, PULL_UP_PORT_PIN_O, CORE_RUN_O,
			PERIPH_STOP_O}), {8'h0, 8'h06, 4'b1110});
		chk(20'(LOW_VOLTAGE_DETECTOR_EN_O), 20'(low_voltage_detector));
	endtask
	task automatic fault(input logic [3:0] f);
		int n;
		{WDT_OVERFLOW_I, ILLEGAL_INSTR_I, RAM_PARITY_ERR_I, ILLEGAL_ACCESS_I} = f;
		@(negedge CLK_I);
		{WDT_OVERFLOW_I, ILLEGAL_INSTR_I, RAM_PARITY_ERR_I, ILLEGAL_ACCESS_I} = 4'h0;
		@(negedge CLK_I);
		chk(20'({CORE_CLK_EN_O, LOW_VOLTAGE_DETECTOR_EN_O, PULL_UP_PORT_PIN_OE_O,
			PULL_UP_PORT_PIN_O}), 20'h3);
		wait_run(n);
	endtask
	task automatic supply(input logic [1:0] ok, input logic [2:0] exp);
		int n;
		{POR_SUPPLY_OK_I, LVD_SUPPLY_OK_I} = ok;
		repeat (8) @(negedge CLK_I);
		chk(20'({CORE_CLK_EN_O, LOW_VOLTAGE_DETECTOR_EN_O, PULL_UP_PORT_PIN_OE_O}), 20'(exp));
		{POR_SUPPLY_OK_I, LVD_SUPPLY_OK_I} = 2'b11;
		wait_run(n);
	endtask
	initial begin
		#160000;
		fail_count++;
		complete_run();
	end
	initial begin
		hard_reset(1'b1);
		pin_cycle(1'b1, t[0]);
		hard_reset(1'b0);
		pin_cycle(1'b0, t[1]);
		pin_cycle(1'b1, t[2]);
		pin_cycle(1'b0, t[3]);
		chk(20'(t[0] >= P_ST + P_FL && t[0] <= P_ST + P_FL + 12), 20'h1);
		chk(20'(t[0] - t[1]), 20'(P_FL - P_FN));
		chk(20'(t[0] - t[2]), 20'(P_ST + P_FL - P_LL));
		chk(20'(t[2] - t[3]), 20'(P_LL - P_LN));
		LVD_ENABLED_I = 1'b1;
		for (int k = 0; k < 4; k++) begin
			fault(4'h8 >> k);
		end
		supply(2'b10, 3'b011);
		supply(2'b01, 3'b000);
		complete_run();
	end
endmodule

// File: bench/vec_rom.sv
// vector table model at the far side of the sequencer's read port
// assumes reads are one-cycle strobes on the sequencer's clock
`timescale 1ns/1ps
module vec_rom #(
	parameter logic [7:0] LO = 8'h5a,
	parameter logic [7:0] HI = 8'hc3
) (
	input wire logic clk_i,
	input wire logic rd_i,
	input wire logic [19:0] addr_i,
	output logic [7:0] data_o
);
	// ====
	// answer one cycle after the strobe, scramble otherwise
	initial data_o = 8'ha5;
	always @(posedge clk_i) begin
		data_o <= rd_i ? (addr_i[0] ? HI : LO) : ~data_o;
	end
endmodule

// File: rtl/chip_reset_sequencer.sv
// chip reset sequencer: collects reset requests, times stabilisation and reset processing,
// fetches the reset vector and releases the core on the fast internal oscillator
// assumes a vector read port on the same clock returning data one cycle after the request
//
// Functional notes
// - low reset pin puts device into reset
// - pin high releases, then reset processing runs
// - start running on fast internal oscillator
// - fault resets release automatically
// - first power-on, detector on: 0.672 ms
// - first power-on, detector off: 0.399 ms
// - later power-on, detector on: 0.531 ms
// - later power-on, detector off: 0.259 ms
// - stabilisation wait after first power application only
// - pull-up pin floats on pin/power resets
// - supply detector resets release above threshold
// - core clock gated during reset
// - crystal oscillator stopped, pins are inputs
// - external clock ignored, pin is input
// - low-voltage detector runs only during own reset
// - program counter loaded from reset vector
// - status word set to 06H
// - only program counter undefined during reset
`timescale 1ns/1ps
module chip_reset_sequencer
	import rst_seq_pkg::*;
#(
	parameter int PROC_FIRST_LVD = CYC_PROC_FIRST_LVD,
	parameter int PROC_FIRST_NOLVD = CYC_PROC_FIRST_NOLVD,
	parameter int PROC_LATER_LVD = CYC_PROC_LATER_LVD,
	parameter int PROC_LATER_NOLVD = CYC_PROC_LATER_NOLVD,
	parameter int STAB_CYCLES = CYC_STAB
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic RESET_N_I,
	input wire logic POR_SUPPLY_OK_I,
	input wire logic LVD_SUPPLY_OK_I,
	input wire logic LVD_ENABLED_I,
	input wire logic WDT_OVERFLOW_I,
	input wire logic ILLEGAL_INSTR_I,
	input wire logic RAM_PARITY_ERR_I,
	input wire logic ILLEGAL_ACCESS_I,
	input wire logic [7:0] VECTOR_DATA_I,
	output logic [19:0] VECTOR_ADDR_O,
	output logic VECTOR_RD_O,
	output logic CORE_CLK_EN_O,
	output logic CORE_RUN_O,
	output logic FAST_OSC_SELECT_O,
	output logic CRYSTAL_OSC_EN_O,
	output logic CRYSTAL_PINS_AS_INPUT_O,
	output logic EXT_CLOCK_ACCEPT_O,
	output logic LOW_VOLTAGE_DETECTOR_EN_O,
	output logic PULL_UP_PORT_PIN_O,
	output logic PULL_UP_PORT_PIN_OE_O,
	output logic PERIPH_STOP_O,
	output logic [19:0] PROGRAM_COUNTER_O,
	output logic PROGRAM_COUNTER_VALID_O,
	output logic [7:0] PROGRAM_STATUS_WORD_O,
	output logic PSW_LOAD_O
);
	// ============================================================
	// input conditioning
	// pin and supply levels are asynchronous to the clock
	logic pin_high;
	logic por_ok;
	logic lvd_ok;

	pin_sync #(.RESET_LEVEL(1'b0)) u_pin_sync (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.async_i(RESET_N_I),
		.level_o(pin_high)
	);

	pin_sync #(.RESET_LEVEL(1'b0)) u_por_sync (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.async_i(POR_SUPPLY_OK_I),
		.level_o(por_ok)
	);

	pin_sync #(.RESET_LEVEL(1'b0)) u_lvd_sync (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.async_i(LVD_SUPPLY_OK_I),
		.level_o(lvd_ok)
	);

	// ============================================================
	// reset request collection
	seq_state_t state_q;
	logic fault_req;
	logic ext_or_por;
	logic lvd_req;
	logic any_req;
	logic lvd_cause_q;
	logic extpor_cause_q;
	logic first_por_q;
	logic por_seen_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] proc_len;

	assign fault_req = WDT_OVERFLOW_I | ILLEGAL_INSTR_I | RAM_PARITY_ERR_I | ILLEGAL_ACCESS_I;
	assign ext_or_por = ~pin_high | ~por_ok;
	// a low-voltage request only counts while the power-on detector is satisfied
	assign lvd_req = LVD_ENABLED_I & ~lvd_ok & por_ok;
	assign any_req = ext_or_por | lvd_req | fault_req;

	function automatic logic [CNT_W-1:0] proc_cycles(input logic first, input logic lvd_on);
		int c;
		if (first) begin
			c = lvd_on ? PROC_FIRST_LVD : PROC_FIRST_NOLVD;
		end else begin
			c = lvd_on ? PROC_LATER_LVD : PROC_LATER_NOLVD;
		end
		return CNT_W'(c);
	endfunction

	assign proc_len = proc_cycles(first_por_q, LVD_ENABLED_I);

	// last cycle of a count that lasts len cycles
	function automatic logic at_last(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] len);
		return cnt >= len - 1'b1;
	endfunction

	// cause of the reset in progress, kept until the core runs
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			lvd_cause_q <= 1'b0;
			extpor_cause_q <= 1'b1;
		end else if (any_req) begin
			lvd_cause_q <= lvd_req & ~ext_or_por;
			extpor_cause_q <= ext_or_por;
		end else if (state_q == ST_RUN) begin
			lvd_cause_q <= 1'b0;
			extpor_cause_q <= 1'b0;
		end
	end

	// first power-on release versus later ones
	// only a hard reset re-arms the longer first-release timing
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			first_por_q <= 1'b1;
			por_seen_q <= 1'b0;
		end else if (state_q == ST_RUN && por_ok && !por_seen_q) begin
			first_por_q <= 1'b0;
			por_seen_q <= 1'b1;
		end
	end

	// ============================================================
	// sequencer
	// any new request restarts from hold; a half-done vector fetch is dropped
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_q <= ST_HOLD;
			cnt_q <= '0;
		end else if (any_req) begin
			state_q <= ST_HOLD;
			cnt_q <= '0;
		end else begin
			case (state_q)
				ST_HOLD: begin
					cnt_q <= '0;
					state_q <= first_por_q ? ST_STAB : ST_PROC;
				end
				ST_STAB: begin
					if (at_last(cnt_q, CNT_W'(STAB_CYCLES))) begin
						cnt_q <= '0;
						state_q <= ST_PROC;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ST_PROC: begin
					if (at_last(cnt_q, proc_len)) begin
						cnt_q <= '0;
						state_q <= ST_VEC_LO;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ST_VEC_LO: state_q <= ST_VEC_HI;
				ST_VEC_HI: state_q <= ST_RUN;
				ST_RUN: state_q <= ST_RUN;
				default: state_q <= ST_HOLD;
			endcase
		end
	end

	// ============================================================
	// reset vector fetch and core state
	logic [7:0] vec_lo_q;
	logic hi_pending_q;

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			VECTOR_ADDR_O <= RESET_VECTOR_LO_ADDR;
			VECTOR_RD_O <= 1'b0;
		end else begin
			VECTOR_RD_O <= !any_req && ((state_q == ST_PROC && at_last(cnt_q, proc_len))
				|| state_q == ST_VEC_LO);
			VECTOR_ADDR_O <= (state_q == ST_VEC_LO) ? RESET_VECTOR_HI_ADDR
				: RESET_VECTOR_LO_ADDR;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			vec_lo_q <= 8'h00;
			hi_pending_q <= 1'b0;
		end else begin
			hi_pending_q <= (state_q == ST_VEC_HI) && !any_req;
			// the port answers one cycle after it sees the strobe, so the low byte
			// stands on the data bus while the high byte is being requested
			if (state_q == ST_VEC_HI) begin
				vec_lo_q <= VECTOR_DATA_I;
			end
		end
	end

	// the program counter is loaded here; the status word is set below and other core state is left to its own logic
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			PROGRAM_COUNTER_O <= PC_RESET;
			PROGRAM_COUNTER_VALID_O <= 1'b0;
		end else if (any_req) begin
			PROGRAM_COUNTER_VALID_O <= 1'b0;
		end else if (hi_pending_q) begin
			PROGRAM_COUNTER_O <= {4'h0, VECTOR_DATA_I, vec_lo_q};
			PROGRAM_COUNTER_VALID_O <= 1'b1;
		end
	end

	// the status word value is fixed; the load strobe tells the core when to take it
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			PROGRAM_STATUS_WORD_O <= PSW_RESET;
			PSW_LOAD_O <= 1'b0;
		end else begin
			PROGRAM_STATUS_WORD_O <= PSW_RESET;
			PSW_LOAD_O <= hi_pending_q && !any_req;
		end
	end

	// ============================================================
	// clock, oscillator and peripheral control
	// the core starts one cycle after the program counter is loaded
	logic running;
	assign running = (state_q == ST_RUN) && PROGRAM_COUNTER_VALID_O && !any_req;

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			CORE_CLK_EN_O <= 1'b0;
			CORE_RUN_O <= 1'b0;
			FAST_OSC_SELECT_O <= 1'b1;
			PERIPH_STOP_O <= 1'b1;
		end else begin
			CORE_CLK_EN_O <= running;
			CORE_RUN_O <= running;
			FAST_OSC_SELECT_O <= 1'b1;
			PERIPH_STOP_O <= !running;
		end
	end

	// crystal and external clock stay off until software starts them
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			CRYSTAL_OSC_EN_O <= 1'b0;
			CRYSTAL_PINS_AS_INPUT_O <= 1'b1;
			EXT_CLOCK_ACCEPT_O <= 1'b0;
		end else begin
			CRYSTAL_OSC_EN_O <= 1'b0;
			CRYSTAL_PINS_AS_INPUT_O <= 1'b1;
			EXT_CLOCK_ACCEPT_O <= 1'b0;
		end
	end

	// the detector keeps running through a reset that it raised itself
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			LOW_VOLTAGE_DETECTOR_EN_O <= 1'b0;
		end else if (running) begin
			LOW_VOLTAGE_DETECTOR_EN_O <= LVD_ENABLED_I;
		end else begin
			LOW_VOLTAGE_DETECTOR_EN_O <= lvd_cause_q || (lvd_req && !ext_or_por);
		end
	end

	// pin and power-on resets float the pull-up pin; other resets pull it high
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			PULL_UP_PORT_PIN_O <= 1'b0;
			PULL_UP_PORT_PIN_OE_O <= 1'b0;
		end else begin
			PULL_UP_PORT_PIN_O <= 1'b1;
			PULL_UP_PORT_PIN_OE_O <= !(ext_or_por || (extpor_cause_q && !running));
		end
	end
endmodule

// File: rtl/pin_sync.sv
// three-stage synchroniser with agreement filter for an asynchronous level
// assumes the level is stable for at least two clock cycles per change
`timescale 1ns/1ps
module pin_sync #(
	parameter logic RESET_LEVEL = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic async_i,
	output logic level_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_q <= RESET_LEVEL;
			s2_q <= RESET_LEVEL;
			s3_q <= RESET_LEVEL;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change counts once stages two and three agree
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			level_o <= RESET_LEVEL;
		end else if (s2_q == s3_q) begin
			level_o <= s3_q;
		end
	end
endmodule

// File: rtl/rst_seq_pkg.sv
// constants for the chip reset sequencer: timing figures, reset vector and status word value
// assumes a single 25 MHz system clock
package rst_seq_pkg;
	localparam int CLK_HZ = 25000000;
	// times in nanoseconds, as printed
	localparam int T_PROC_FIRST_LVD_NS = 672000;
	localparam int T_PROC_FIRST_NOLVD_NS = 399000;
	localparam int T_PROC_LATER_LVD_NS = 531000;
	localparam int T_PROC_LATER_NOLVD_NS = 259000;
	localparam int T_STAB_NS = 990000;
	localparam int T_EXT_MIN_NS = 10000;
	localparam int NS_PER_S = 1000000000;
	// typical times become cycle counts, rounded up
	localparam int CYC_PROC_FIRST_LVD = (T_PROC_FIRST_LVD_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int CYC_PROC_FIRST_NOLVD = (T_PROC_FIRST_NOLVD_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int CYC_PROC_LATER_LVD = (T_PROC_LATER_LVD_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int CYC_PROC_LATER_NOLVD = (T_PROC_LATER_NOLVD_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int CYC_STAB = (T_STAB_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int CYC_EXT_MIN = (T_EXT_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int CNT_W = 16;
	localparam logic [19:0] RESET_VECTOR_LO_ADDR = 20'h00000;
	localparam logic [19:0] RESET_VECTOR_HI_ADDR = 20'h00001;
	localparam logic [7:0] PSW_RESET = 8'h06;
	localparam logic [19:0] PC_RESET = 20'h00000;

	typedef enum logic [2:0] {
		ST_HOLD = 3'b000,
		ST_STAB = 3'b001,
		ST_PROC = 3'b011,
		ST_VEC_LO = 3'b010,
		ST_VEC_HI = 3'b110,
		ST_RUN = 3'b111
	} seq_state_t;
endpackage
